// *** rtl/aef_pkg.sv ***
// Purpose: Constants and types for the ADC event flag register bank
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Interrupt enable register shares the flag register layout
// Behaviour
// - Per-conversion mode: done flag follows result valid
// - Per-conversion mode: global result read clears flag
// - Sequence mode: flag set on whole sequence done
// - Sequence mode: flag held until one written
// - Request raised only when enable bit set
// - Bit 24 mirrors global overrun status
// - Bits 19-12 mirror channel overrun status
// - Threshold event bit set on enabled event
// - Threshold bit cleared by writing one
// - Reserved bits written zero, read as zero
// - Bit 31 set by any channel overrun, or by global overrun in per-conversion mode only
// - Bit 30 set while any threshold bit set
package aef_pkg;
   localparam int                 NUM_CH          = 8;
   localparam logic [7:0]         ADDR_FLAGS      = 8'h68;
   localparam logic [7:0]         ADDR_INT_EN     = 8'h00;
   localparam logic [7:0]         ADDR_CTRL       = 8'h04;
   localparam int                 BIT_OVR_IRQ     = 31;
   localparam int                 BIT_THR_IRQ     = 30;
   localparam int                 BIT_SEQ_DONE    = 28;
   localparam int                 BIT_SEQ_OVR     = 24;
   localparam int                 LSB_CH_OVR      = 12;
   localparam int                 LSB_THR         = 0;
   localparam int                 BIT_MODE        = 0;
   localparam logic [31:0]        FLAGS_RESET     = 32'h0000_0000;
   localparam logic [31:0]        INT_EN_RESET    = 32'h0000_0000;

   typedef struct packed {
      logic                     result_valid;
      logic                     seq_complete;
      logic                     global_rd;
      logic                     global_ovr;
      logic [NUM_CH-1:0]        ch_ovr;
      logic [NUM_CH-1:0]        thr_event;
   } aef_events_t;
endpackage

// *** rtl/aef_w1c_bit.sv ***
// Purpose: One sticky flag, set by hardware, cleared by write of one
// Assumes: Set wins over clear in the same cycle
// Notes:   Used for threshold events and sequence done flag
`timescale 1ns/10ps
`default_nettype none
module aef_w1c_bit (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   logic flag_q;
   logic flag_d;
   assign flag_d = set_i | (flag_q & ~clr_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) flag_q <= 1'b0;
      else       flag_q <= flag_d;
   end
   assign flag_o = flag_q;
endmodule
`default_nettype wire

// *** rtl/aef_flags.sv ***
// Purpose: ADC event flag register with interrupt enable and mode control
// Assumes: Classic Wishbone, one wait state, events synchronous to clk_i
// Notes:   Single level interrupt output gated by enable register
`timescale 1ns/10ps
`default_nettype none
module aef_flags #(
   parameter int NCH = aef_pkg::NUM_CH
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire aef_pkg::aef_events_t ev_i,
   output logic                      irq_o,
   output logic                      seq_dma_req_o
);
   import aef_pkg::*;

   // ==================================================
   // Bus decode
   logic        ack_q;
   logic        acc;
   logic        wr;
   logic        hit_flags;
   logic        hit_en;
   logic        hit_ctrl;
   logic [31:0] wmask;
   logic [31:0] wdat;
   assign acc       = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr        = acc & wb_we_i;
   assign hit_flags = (wb_adr_i == ADDR_FLAGS);
   assign hit_en    = (wb_adr_i == ADDR_INT_EN);
   assign hit_ctrl  = (wb_adr_i == ADDR_CTRL);
   assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdat      = wb_dat_i & wmask;

   // ==================================================
   // Control and enable registers
   logic [31:0] int_en_q;
   logic        mode_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_en_q <= INT_EN_RESET;
         mode_q   <= 1'b0;
      end else begin
         if (wr && hit_en)   int_en_q <= (int_en_q & ~wmask) | wdat;
         if (wr && hit_ctrl && wb_sel_i[0]) mode_q <= wb_dat_i[BIT_MODE];
      end
   end

   // ==================================================
   // Flags
   logic            wr_flags;
   logic            seq_set;
   logic            seq_clr;
   logic            seq_flag;
   logic [NCH-1:0]  thr_q;
   logic [NCH-1:0]  thr_en;
   logic            ovr_any;
   logic            thr_any;
   assign wr_flags = wr & hit_flags;
   assign thr_en   = int_en_q[LSB_THR +: NCH];
   // Per-conversion: set on valid, clear on global result read
   // Sequence mode: set on completion, clear by writing one
   assign seq_set = mode_q ? ev_i.seq_complete : ev_i.result_valid;
   assign seq_clr = mode_q ? (wr_flags & wdat[BIT_SEQ_DONE])
                           : ev_i.global_rd;
   aef_w1c_bit u_seq (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (seq_set),
      .clr_i  (seq_clr),
      .flag_o (seq_flag)
   );
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_thr
         aef_w1c_bit u_thr (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .set_i  (ev_i.thr_event[g] & thr_en[g]),
            .clr_i  (wr_flags & wdat[LSB_THR + g]),
            .flag_o (thr_q[g])
         );
      end
   endgenerate
   assign ovr_any = (|ev_i.ch_ovr) | (~mode_q & ev_i.global_ovr);
   assign thr_any = |thr_q;

   // ==================================================
   // Read data and interrupt
   logic [31:0] flags_v;
   logic [31:0] rd_mux;
   always_comb begin
      flags_v = FLAGS_RESET;
      flags_v[BIT_OVR_IRQ]              = ovr_any;
      flags_v[BIT_THR_IRQ]              = thr_any;
      flags_v[BIT_SEQ_DONE]             = seq_flag;
      flags_v[BIT_SEQ_OVR]              = ev_i.global_ovr;
      flags_v[LSB_CH_OVR +: NCH]        = ev_i.ch_ovr;
      flags_v[LSB_THR +: NCH]           = thr_q;
   end
   assign rd_mux = hit_flags ? flags_v :
                   hit_en    ? int_en_q :
                   hit_ctrl  ? {31'h0, mode_q} : 32'h0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q    <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_q    <= acc;
         wb_dat_o <= acc ? rd_mux : 32'h0;
      end
   end
   assign wb_ack_o = ack_q;
   assign seq_dma_req_o = seq_flag & int_en_q[BIT_SEQ_DONE];
   assign irq_o = (ovr_any & int_en_q[BIT_OVR_IRQ]) |
                  (thr_any & int_en_q[BIT_THR_IRQ]) |
                  (seq_flag & int_en_q[BIT_SEQ_DONE]);
endmodule
`default_nettype wire

// *** sim/aef_flags_asserts.sv ***
// Purpose: Port checks for aef_flags
// Assumes: One wait state bus, read data registered at the take edge
// Notes:   Bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module aef_chk (
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [7:0]           wb_adr_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire aef_pkg::aef_events_t ev_i,
   input wire logic                 irq_o,
   input wire logic                 seq_dma_req_o
);
   import aef_pkg::*;
   logic        rd_q;
   aef_events_t ev_q;
   wire         rd = wb_ack_o & rd_q;
   // Flag read in flight and the inputs seen at its take edge
   always_ff @(posedge clk_i) begin
      rd_q <= wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i & (wb_adr_i == ADDR_FLAGS);
      ev_q <= ev_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_one_wait: assert property (wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_dma_needs_irq: assert property (seq_dma_req_o |-> irq_o)
      else $error("dma without irq");
   a_seq_ovr_copy: assert property (rd |-> wb_dat_o[24] == ev_q.global_ovr)
      else $error("bit 24 wrong");
   a_ch_ovr_copy: assert property (rd |-> wb_dat_o[19:12] == ev_q.ch_ovr)
      else $error("bits 19-12 wrong");
   a_rsvd_zero: assert property (rd |-> wb_dat_o[27:25] == 0 && wb_dat_o[23:20] == 0 && wb_dat_o[11:8] == 0)
      else $error("reserved set");
   a_ovr_irq_set: assert property (rd && wb_dat_o[19:12] != 0 |-> wb_dat_o[31])
      else $error("bit 31 low");
   a_thr_irq_any: assert property (rd |-> wb_dat_o[30] == |wb_dat_o[7:0])
      else $error("bit 30 wrong");
endmodule
bind aef_flags aef_chk u_chk (.*);
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for aef_flags
// Assumes: One wait state bus, all enables set unless noted
// Notes:   Model held in plain variables
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import aef_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, dma, md = 0, sq = 0;
   logic [7:0]  adr = 0, thr = 0, c;
   logic [31:0] dat = 0, rdat, q, en = 0;
   aef_events_t ev = '0;
   int          err_total = 0, check_count = 0;
   aef_flags uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ev_i(ev), .irq_o(irq), .seq_dma_req_o(dma));
   function automatic logic [31:0] fl();
      fl = {|ev.ch_ovr | (~md & ev.global_ovr), |thr, 1'b0, sq, 3'h0, ev.global_ovr, 4'h0,
            ev.ch_ovr, 4'h0, thr};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20) err_total++;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask
   // Read compare, then the request outputs against the model
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] f;
      wb(1'b0, a, 32'h0);
      chk(q, e);
      f = fl() & en;
      chk({30'h0, dma, irq}, {30'h0, f[28], f[31] | f[30] | f[28]});
   endtask
   task automatic pulse(input logic [2:0] s, input logic [7:0] t);
      {ev.result_valid, ev.seq_complete, ev.global_rd, ev.thr_event} <= {s, t};
      @(posedge clk_i);
      {ev.result_valid, ev.seq_complete, ev.global_rd, ev.thr_event} <= '0;
      @(posedge clk_i);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      #20000;
      err_total++;
      test_done;
   end
   initial begin
      c = 8'($urandom(32'hb2c39b4e));
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rd(ADDR_FLAGS, 32'h0);
      wb(1'b1, 8'h20, 32'hffff_ffff);
      rd(8'h20, 32'h0);
      en = 32'hd000_00ff;
      wb(1'b1, ADDR_INT_EN, en);
      rd(ADDR_INT_EN, en);
      $display("register test done");
      thr = 8'($urandom) | 8'h81;
      pulse(3'b000, thr);
      rd(ADDR_FLAGS, fl());
      c = 8'($urandom);
      wb(1'b1, ADDR_FLAGS, {12'h0, 8'hff, 4'h0, c});
      thr = thr & ~c;
      rd(ADDR_FLAGS, fl());
      wb(1'b1, ADDR_FLAGS, {24'h0, thr});
      thr = 0;
      rd(ADDR_FLAGS, fl());
      $display("threshold test done");
      {ev.ch_ovr, ev.global_ovr} <= {8'($urandom) | 8'h10, 1'b1};
      @(posedge clk_i);
      rd(ADDR_FLAGS, fl());
      ev.ch_ovr <= 8'h0;
      @(posedge clk_i);
      rd(ADDR_FLAGS, fl());
      $display("overrun test done");
      pulse(3'b100, 8'h0);
      sq = 1;
      rd(ADDR_FLAGS, fl());
      pulse(3'b001, 8'h0);
      sq = 0;
      rd(ADDR_FLAGS, fl());
      md = 1;
      wb(1'b1, ADDR_CTRL, 32'h1);
      pulse(3'b100, 8'h0);
      rd(ADDR_FLAGS, fl());
      pulse(3'b010, 8'h0);
      sq = 1;
      pulse(3'b001, 8'h0);
      wb(1'b1, ADDR_FLAGS, 32'h0);
      rd(ADDR_FLAGS, fl());
      en = 32'hc000_00ff;
      wb(1'b1, ADDR_INT_EN, en);
      rd(ADDR_FLAGS, fl());
      wb(1'b1, ADDR_FLAGS, 32'h1000_0000);
      sq = 0;
      rd(ADDR_FLAGS, fl());
      en = 32'h4000_000f;
      wb(1'b1, ADDR_INT_EN, en);
      pulse(3'b000, 8'hff);
      thr = 8'h0f;
      rd(ADDR_FLAGS, fl());
      $display("sequence test done");
      test_done;
   end
endmodule
`default_nettype wire
